// >>> rtl/tenbase_t_pkg.sv
// Purpose: Shared constants for the 10BASE-T control and status register block.
// Assumes: AXI4-Lite with 32-bit data; the printed offset is a register index.
// Notes:   Byte address of each register is four times its index.
`default_nettype none
package tenbase_t_pkg;
    localparam int          ADDR_W            = 8;
    // Register indices as printed, and indices of the added registers.
    localparam logic [7:0]  IDX_CTRL_STATUS   = 8'h1A;
    localparam logic [7:0]  IDX_IRQ_STATUS    = 8'h20;
    localparam logic [7:0]  IDX_IRQ_MASK      = 8'h21;
    localparam logic [7:0]  IDX_PHY_STATUS    = 8'h10;
    localparam logic [7:0]  IDX_LINK_STATUS   = 8'h22;
    // Field positions of the control and status register, and of the polarity bit in the PHY status copy.
    localparam int          BIT_RSVD_TOP      = 15;
    localparam int          BIT_SQUELCH_LO    = 9;
    localparam int          BIT_LOOP_DIS      = 8;
    localparam int          BIT_LP_TX_DIS     = 7;
    localparam int          BIT_FORCE_LINK    = 6;
    localparam int          BIT_POL_FORCE     = 5;
    localparam int          BIT_POL_STATUS    = 4;
    localparam int          BIT_AUTO_POLARITY_FIX_DISABLE   = 3;
    localparam int          BIT_SIL_UPPER     = 2;
    localparam int          BIT_SQE_DIS       = 1;
    localparam int          BIT_TX_OVERLENGTH_GUARD_DISABLE    = 0;
    localparam int          BIT_PHY_STATUS_SUMMARY_POL    = 12;
    // Writable bits of the control register: 14:5, 3:0.
    localparam logic [15:0] CTRL_WR_MASK      = 16'h7FEF;
    localparam logic [15:0] CTRL_RESET        = 16'h0804;
    // Interrupt status bits.
    localparam int          IRQ_POL_INV       = 0;
    localparam int          IRQ_LINK_CHG      = 1;
    localparam logic [1:0]  IRQ_RESET         = 2'h0;
    // AXI responses.
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    function automatic logic [7:0] wordIndex(input logic [ADDR_W-1:0] addr);
        return {2'h0, addr[ADDR_W-1:2]};
    endfunction
endpackage
`default_nettype wire

// >>> rtl/sync_two_ff.sv
// Purpose: Two flip-flop synchroniser for a single level.
// Assumes: Input is asynchronous to clk.
// Notes:   Only the second stage may be read by other logic.
`default_nettype none
module sync_two_ff (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1_reg <= 1'b0;
            syncOut    <= 1'b0;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/edge_latch.sv
// Purpose: Latch-high flag with a clear input, where a new set wins over the clear.
// Assumes: Inputs are on clk.
// Notes:   Used for the polarity status and the interrupt status bits.
`default_nettype none
module edge_latch (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic setIn,
    input  wire logic clearIn,
    output logic      flag
);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag <= 1'b0;
        end else if (setIn) begin
            flag <= 1'b1;
        end else if (clearIn) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/tenbase_t_control_status.sv
// Purpose: 10BASE-T control and status register with AXI4-Lite access.
// Assumes: Line status inputs arrive from pins or other clocks and are synchronised.
// Notes:   Outputs are registered; jabber disable is ignored at 100 Mb.
// Function
// [RL1] Top bit ignores writes, reads zero.
// [RL2] Squelch field bits 11:9 resets to 100.
// [RL3] Bit 8 disables the basic loopback bit.
// [RL4] Bit 7 or force input stops pulses.
// [RL5] Bit 6 or force input forces link.
// [RL6] Bit 5 forces inverted receive polarity.
// [RL7] Polarity latch mirrored; either read clears.
// [RL8] Bit 3 disables automatic polarity correction.
// [RL9] Bit 2 resets one, selects silence threshold.
// [RL10] Bit 1 disables heartbeat in half-duplex 10Mb.
// [RL11] Heartbeat off at 100Mb or full duplex.
// [RL12] Bit 0 disables jabber in 10BASE-T.
// [RL13] Reset loads defaults; reserved bits written zero.
`default_nettype none
module tenbase_t_control_status (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        basicModeLoopback,
    input  wire logic        externalTenMbLinkForce,
    input  wire logic        polarityInvertedDetect,
    input  wire logic        rawLinkGood,
    input  wire logic        speed100,
    input  wire logic        fullDuplex,
    input  wire logic        signalDetectBit10,
    output logic             tenMbLoopEnable,
    output logic             normalLinkPulseTxEnable,
    output logic             linkGood,
    output logic             invertedPolarityForce,
    output logic             autoPolarityFixEnable,
    output logic [2:0]       squelchLevel,
    output logic [1:0]       silenceThresholdSel,
    output logic             sqeTestEnable,
    output logic             txOverlengthGuardEnable,
    output logic             irq
);
    logic [15:0] ctrl_reg;
    logic [1:0]  irqMask_reg;
    logic [1:0]  irqStatus;
    logic        polStatus;
    logic        forceSync;
    logic        polSync;
    logic        linkSync;
    logic        speedSync;
    logic        duplexSync;
    logic        linkPrev_reg;
    logic        awHeld_reg;
    logic        wHeld_reg;
    logic [7:0]  awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0]  wStrb_reg;
    logic        doWrite;
    logic        doRead;
    logic        polReadClear;
    logic [7:0]  wIdx;
    logic [7:0]  rIdx;
    logic [15:0] ctrlView;
    logic        linkNow;

    sync_two_ff syncForce (.clk(clk), .resetn(resetn), .asyncIn(externalTenMbLinkForce),
                           .syncOut(forceSync));
    sync_two_ff syncPol   (.clk(clk), .resetn(resetn), .asyncIn(polarityInvertedDetect),
                           .syncOut(polSync));
    sync_two_ff syncLink  (.clk(clk), .resetn(resetn), .asyncIn(rawLinkGood),
                           .syncOut(linkSync));
    sync_two_ff syncSpeed (.clk(clk), .resetn(resetn), .asyncIn(speed100),
                           .syncOut(speedSync));
    sync_two_ff syncDup   (.clk(clk), .resetn(resetn), .asyncIn(fullDuplex),
                           .syncOut(duplexSync));

    // Write channel: address and data may arrive in either order.
    assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign wIdx    = tenbase_t_pkg::wordIndex(awAddr_reg);
    assign doRead  = s_axi_arvalid && s_axi_arready;
    assign rIdx    = tenbase_t_pkg::wordIndex(s_axi_araddr);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awHeld_reg    <= 1'b0;
            wHeld_reg     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awAddr_reg    <= 8'h00;
            wData_reg     <= 32'h00000000;
            wStrb_reg     <= 4'h0;
        end else begin
            s_axi_awready <= !awHeld_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wHeld_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= tenbase_t_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wIdx == tenbase_t_pkg::IDX_CTRL_STATUS ||
                             wIdx == tenbase_t_pkg::IDX_IRQ_STATUS ||
                             wIdx == tenbase_t_pkg::IDX_IRQ_MASK) ?
                            tenbase_t_pkg::RESP_OKAY : tenbase_t_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register; reserved bits 14:12 stay writable and software keeps them zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= tenbase_t_pkg::CTRL_RESET; // [RL2] [RL9] [RL13]
        end else if (doWrite && wIdx == tenbase_t_pkg::IDX_CTRL_STATUS) begin
            if (wStrb_reg[0]) begin
                ctrl_reg[7:0] <= wData_reg[7:0] & tenbase_t_pkg::CTRL_WR_MASK[7:0];
            end
            if (wStrb_reg[1]) begin
                ctrl_reg[15:8] <= wData_reg[15:8] & tenbase_t_pkg::CTRL_WR_MASK[15:8]; // [RL1]
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqMask_reg <= tenbase_t_pkg::IRQ_RESET;
        end else if (doWrite && wIdx == tenbase_t_pkg::IDX_IRQ_MASK && wStrb_reg[0]) begin
            irqMask_reg <= wData_reg[1:0];
        end
    end

    // A read of this register or of the PHY status copy clears the shared latch.
    assign polReadClear = doRead && (rIdx == tenbase_t_pkg::IDX_CTRL_STATUS ||
                                     rIdx == tenbase_t_pkg::IDX_PHY_STATUS);

    edge_latch polLatch (.clk(clk), .resetn(resetn), .setIn(polSync),
                         .clearIn(polReadClear), .flag(polStatus)); // [RL7]

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            linkPrev_reg <= 1'b0;
        end else begin
            linkPrev_reg <= linkNow;
        end
    end

    genvar g;
    for (g = 0; g < 2; g++) begin : irqBits
        logic evt;
        assign evt = (g == tenbase_t_pkg::IRQ_POL_INV) ? (polSync && !polStatus)
                                                       : (linkNow != linkPrev_reg);
        edge_latch irqLatch (.clk(clk), .resetn(resetn), .setIn(evt),
                             .clearIn(doWrite && wIdx == tenbase_t_pkg::IDX_IRQ_STATUS &&
                                      wStrb_reg[0] && wData_reg[g]),
                             .flag(irqStatus[g]));
    end

    always_comb begin
        ctrlView = ctrl_reg;
        ctrlView[tenbase_t_pkg::BIT_RSVD_TOP]   = 1'b0; // [RL1]
        ctrlView[tenbase_t_pkg::BIT_POL_STATUS] = polStatus; // [RL7]
    end

    // Read channel: one read at a time, answered one cycle after the address is taken.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= tenbase_t_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (doRead) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= tenbase_t_pkg::RESP_OKAY;
                case (rIdx)
                    tenbase_t_pkg::IDX_CTRL_STATUS: s_axi_rdata <= {16'h0000, ctrlView};
                    tenbase_t_pkg::IDX_PHY_STATUS:
                        s_axi_rdata <= {19'h00000, polStatus, 12'h000}; // [RL7]
                    tenbase_t_pkg::IDX_IRQ_STATUS:  s_axi_rdata <= {30'h00000000, irqStatus};
                    tenbase_t_pkg::IDX_IRQ_MASK:    s_axi_rdata <= {30'h00000000, irqMask_reg};
                    tenbase_t_pkg::IDX_LINK_STATUS: s_axi_rdata <= {31'h00000000, linkNow};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= tenbase_t_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign linkNow = linkSync || ctrl_reg[tenbase_t_pkg::BIT_FORCE_LINK] || forceSync; // [RL5]

    // Controls are registered so that every output comes from a flip-flop.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tenMbLoopEnable         <= 1'b0;
            normalLinkPulseTxEnable <= 1'b0;
            linkGood                <= 1'b0;
            invertedPolarityForce   <= 1'b0;
            autoPolarityFixEnable   <= 1'b0;
            squelchLevel            <= 3'h0;
            silenceThresholdSel     <= 2'h0;
            sqeTestEnable           <= 1'b0;
            txOverlengthGuardEnable <= 1'b0;
            irq                     <= 1'b0;
        end else begin
            tenMbLoopEnable <= basicModeLoopback &&
                               !(ctrl_reg[tenbase_t_pkg::BIT_LOOP_DIS]); // [RL3]
            normalLinkPulseTxEnable <= !(ctrl_reg[tenbase_t_pkg::BIT_LP_TX_DIS] ||
                                         forceSync); // [RL4]
            linkGood              <= linkNow; // [RL5]
            invertedPolarityForce <= ctrl_reg[tenbase_t_pkg::BIT_POL_FORCE]; // [RL6]
            autoPolarityFixEnable <= !ctrl_reg[tenbase_t_pkg::BIT_AUTO_POLARITY_FIX_DISABLE]; // [RL8]
            squelchLevel <= ctrl_reg[tenbase_t_pkg::BIT_SQUELCH_LO +: 3]; // [RL2]
            silenceThresholdSel <= {ctrl_reg[tenbase_t_pkg::BIT_SIL_UPPER],
                                    signalDetectBit10}; // [RL9]
            sqeTestEnable <= !ctrl_reg[tenbase_t_pkg::BIT_SQE_DIS] // [RL10]
                             && !speedSync && !duplexSync; // [RL11]
            txOverlengthGuardEnable <= speedSync ||
                                       !ctrl_reg[tenbase_t_pkg::BIT_TX_OVERLENGTH_GUARD_DISABLE]; // [RL12]
            irq <= |(irqStatus & irqMask_reg);
        end
    end
endmodule
`default_nettype wire

// >>> testbench/tenbase_t_asserts.sv
// Purpose: Port-level checks of the 10BASE-T control and status register.
// Assumes: Synchronised line inputs reach the outputs within four cycles.
// Notes:   Rules that hang on the hidden register value are left to the bench.
`default_nettype none
module tenbase_t_asserts (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        externalTenMbLinkForce,
    input wire logic        speed100,
    input wire logic        fullDuplex,
    input wire logic        basicModeLoopback,
    input wire logic        signalDetectBit10,
    input wire logic        linkGood,
    input wire logic        normalLinkPulseTxEnable,
    input wire logic        sqeTestEnable,
    input wire logic        txOverlengthGuardEnable,
    input wire logic        tenMbLoopEnable,
    input wire logic [1:0]  silenceThresholdSel,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] live;
    // Delays the input comparison so that values sampled in reset are never used.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            live <= 2'h0;
        end else begin
            live <= {live[0], 1'b1};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence forceHeld;
        externalTenMbLinkForce [*5];
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    force_link_a: assert property (forceHeld |-> linkGood)
        else $error("Forced link not reported.");
    pulse_stop_a: assert property (forceHeld |-> !normalLinkPulseTxEnable)
        else $error("Link pulses not stopped by force.");
    sqe_off_a: assert property ((speed100 || fullDuplex) [*5] |-> !sqeTestEnable)
        else $error("Heartbeat enabled at 100 Mb or full duplex.");
    jabber_keep_a: assert property (speed100 [*5] |-> txOverlengthGuardEnable)
        else $error("Jabber guard off at 100 Mb.");
    loop_gate_a: assert property (tenMbLoopEnable |-> $past(basicModeLoopback))
        else $error("Loopback enabled without request.");
    silence_sel_a: assert property (
        live[1] |-> silenceThresholdSel[0] == $past(signalDetectBit10))
        else $error("Silence select low bit wrong.");
    top_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h00000)
        else $error("Read data top bits not zero.");
    rd_answer_a: assert property (rdTaken |=> s_axi_rvalid)
        else $error("Read answer late.");
    rd_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data not held.");
endmodule
bind tenbase_t_control_status tenbase_t_asserts i_tenbase_t_asserts (.clk, .resetn,
    .externalTenMbLinkForce, .speed100, .fullDuplex, .basicModeLoopback, .signalDetectBit10,
    .linkGood, .normalLinkPulseTxEnable, .sqeTestEnable, .txOverlengthGuardEnable,
    .tenMbLoopEnable, .silenceThresholdSel, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// >>> testbench/tenbase_t_control_status_tb_top.sv
// Purpose: Self-checking bench for the 10BASE-T control and status register.
// Assumes: AXI4-Lite slave; byte address is four times the register index.
// Notes:   Synchronised inputs get six cycles, since the sync adds two to the output lag.
`default_nettype none
module tenbase_t_control_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] A_CTRL = 8'h68;
    localparam logic [7:0] A_PHY  = 8'h40;
    localparam logic [7:0] A_IST  = 8'h80;
    localparam logic [7:0] A_IMSK = 8'h84;
    localparam logic [7:0] A_LINK = 8'h88;
    logic        clk = 1'b0, resetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, basicModeLoopback = 1'b1;
    logic        externalTenMbLinkForce = 1'b0, polarityInvertedDetect = 1'b0;
    logic        rawLinkGood = 1'b0, speed100 = 1'b0, fullDuplex = 1'b0, signalDetectBit10 = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, lastResp, silenceThresholdSel;
    logic        tenMbLoopEnable, normalLinkPulseTxEnable, linkGood, invertedPolarityForce;
    logic        autoPolarityFixEnable, sqeTestEnable, txOverlengthGuardEnable;
    logic [2:0]  squelchLevel;
    int          fails = 0, n_compared = 0;
    wire  [31:0] outs = {20'h00000, tenMbLoopEnable, normalLinkPulseTxEnable, linkGood,
        invertedPolarityForce, autoPolarityFixEnable, squelchLevel, silenceThresholdSel,
        sqeTestEnable, txOverlengthGuardEnable};
    always #2.5 clk = ~clk;
    tenbase_t_control_status i_tenbase_t_control_status (.clk, .resetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .basicModeLoopback,
        .externalTenMbLinkForce, .polarityInvertedDetect, .rawLinkGood, .speed100, .fullDuplex,
        .signalDetectBit10, .tenMbLoopEnable, .normalLinkPulseTxEnable, .linkGood,
        .invertedPolarityForce, .autoPolarityFixEnable, .squelchLevel, .silenceThresholdSel,
        .sqeTestEnable, .txOverlengthGuardEnable, .irq);
    task automatic tally_and_finish();
        $display("Compared %0d, mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic checkBit(input logic got, input logic exp);
        checkWord({31'h00000000, got}, {31'h00000000, exp});
    endtask
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 100) begin
            fails++;
            $display("FAIL at %0t: no bus answer", $time);
            tally_and_finish();
        end
    endtask
    task automatic axiWrite(input logic [7:0] a, input logic [15:0] d, input logic [3:0] st);
        int n = 0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {16'h0000, d};
        s_axi_wstrb   <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            tick(n);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        lastResp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRead(input logic [7:0] a, output logic [31:0] d);
        int n = 0;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            tick(n);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        lastResp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
    endtask
    // Short pulse: the detector must latch it, since software may read much later.
    task automatic pulsePol();
        polarityInvertedDetect <= 1'b1;
        settle(4);
        polarityInvertedDetect <= 1'b0;
        settle(4);
    endtask
    initial begin
        settle(12);
        resetn <= 1'b1;
        axiRead(A_CTRL, rd);
        checkWord(rd, 32'h00000804);
        checkWord(outs, 32'h00000CCB);
        axiWrite(A_CTRL, 16'hFFFF, 4'hF);
        checkWord({30'h00000000, lastResp}, {30'h00000000, tenbase_t_pkg::RESP_OKAY});
        axiRead(A_CTRL, rd);
        checkWord(rd, 32'h00007FEF);
        checkWord(outs, 32'h00000378);
        signalDetectBit10 <= 1'b1;
        axiWrite(A_CTRL, 16'h0000, 4'hF);
        axiWrite(A_CTRL, 16'hFFFF, 4'h1);
        axiRead(A_CTRL, rd);
        checkWord(rd, 32'h000000EF);
        checkWord(outs, 32'h00000B0C);
        axiWrite(A_CTRL, 16'h0000, 4'hF);
        settle(3);
        checkWord(outs, 32'h00000C87);
        externalTenMbLinkForce <= 1'b1;
        settle(6);
        checkWord(outs, 32'h00000A87);
        externalTenMbLinkForce <= 1'b0;
        axiWrite(A_CTRL, 16'h0001, 4'hF);
        settle(6);
        checkWord(outs, 32'h00000C86);
        speed100 <= 1'b1;
        settle(6);
        checkWord(outs, 32'h00000C85);
        speed100   <= 1'b0;
        fullDuplex <= 1'b1;
        settle(6);
        checkWord(outs, 32'h00000C84);
        fullDuplex <= 1'b0;
        axiWrite(A_CTRL, 16'h0002, 4'hF);
        settle(6);
        checkWord(outs, 32'h00000C85);
        pulsePol();
        checkBit(irq, 1'b0);
        axiRead(A_CTRL, rd);
        checkBit(rd[4], 1'b1);
        axiRead(A_CTRL, rd);
        checkWord(rd, 32'h00000002);
        axiRead(A_IST, rd);
        checkBit(rd[0], 1'b1);
        axiWrite(A_IMSK, 16'h0003, 4'hF);
        settle(3);
        checkBit(irq, 1'b1);
        // The link change bit is set as well, so both bits must be cleared to drop the line.
        axiWrite(A_IST, 16'h0003, 4'hF);
        settle(3);
        checkBit(irq, 1'b0);
        pulsePol();
        axiRead(A_PHY, rd);
        checkWord(rd, 32'h00001000);
        axiRead(A_CTRL, rd);
        checkWord(rd, 32'h00000002);
        rawLinkGood <= 1'b1;
        settle(6);
        axiRead(A_LINK, rd);
        checkBit(rd[0], 1'b1);
        axiRead(A_IST, rd);
        checkWord(rd, 32'h00000003);
        axiRead(8'hF0, rd);
        checkWord({rd[31:2], lastResp}, {30'h00000000, tenbase_t_pkg::RESP_SLVERR});
        axiWrite(8'hF0, 16'hFFFF, 4'hF);
        checkWord({30'h00000000, lastResp}, {30'h00000000, tenbase_t_pkg::RESP_SLVERR});
        checkBit(tenMbLoopEnable, 1'b1);
        basicModeLoopback <= 1'b0;
        settle(3);
        checkBit(tenMbLoopEnable, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
